// File: common/ttr_map.vh
`ifndef TTR_MAP_VH
`define TTR_MAP_VH

// Register byte addresses on the microprocessor port
`define TTR_OFS_CONTROL 8'hf0
`define TTR_OFS_POINTER 8'hf2
`define TTR_OFS_LIVE 8'hf4
`define TTR_OFS_STICKY 8'hf6
`define TTR_OFS_IRQ_EN 8'hf8
`define TTR_OFS_UNUSED 8'hfa
`define TTR_OFS_RX_BYTE 8'hfc
`define TTR_OFS_EXP_BYTE 8'hfe

// Control register fields
`define TTR_CTL_REORDER 0
`define TTR_CTL_INVERT 1
`define TTR_CTL_COMPARE 2
`define TTR_CTL_ALIGN_DIS 3
`define TTR_CTL_MASK 16'h000f

// Pointer register fields
`define TTR_PTR_RX_LSB 0
`define TTR_PTR_EXP_LSB 8

// Live and sticky status fields
`define TTR_ST_IDLE 0
`define TTR_ST_UNSTABLE 1
`define TTR_ST_MISMATCH 2
`define TTR_ST_CHANGE 3

// Reset values
`define TTR_RST_CONTROL 16'h0000
`define TTR_RST_POINTER 16'h0000
`define TTR_RST_STATUS 4'h0
`define TTR_RST_IDENT 128'h0

// Identifier counts
`define TTR_ID_BYTES 16
`define TTR_IDLE_COUNT 3'h5
`define TTR_UNSTABLE_COUNT 4'h8

`endif

// File: rtl/ttr_deser.v
`timescale 1ns/100ps
`default_nettype none

module ttr_deser (
   input wire clk,
   input wire rst_b,
   input wire trace_bit,
   input wire trace_bit_en,
   input wire trace_byte_start,
   input wire rx_invert_enable,
   input wire rx_bit_reorder_enable,
   output reg [7:0] byte_data_reg,
   output reg byte_first_bit_reg,
   output reg byte_valid_reg
);

reg [7:0] shift_reg;
reg [2:0] count_reg;
reg first_reg;
wire data_bit;
wire [2:0] count_now;
wire [7:0] shift_next;

assign data_bit = trace_bit ^ rx_invert_enable;
assign count_now = trace_byte_start ? 3'h0 : count_reg;
// first bit lands in bit 7, or bit 0 when reordering
assign shift_next = rx_bit_reorder_enable ?
                    {data_bit, shift_reg[7:1]} :
                    {shift_reg[6:0], data_bit};

always @(posedge clk or negedge rst_b) begin
   if (!rst_b) begin
      shift_reg <= 8'h00;
      count_reg <= 3'h0;
      first_reg <= 1'b0;
      byte_data_reg <= 8'h00;
      byte_first_bit_reg <= 1'b0;
      byte_valid_reg <= 1'b0;
   end else begin
      byte_valid_reg <= 1'b0;
      if (trace_bit_en) begin
         shift_reg <= shift_next;
         count_reg <= count_now + 3'h1;
         if (count_now == 3'h0) begin
            first_reg <= data_bit;
         end
         if (count_now == 3'h7) begin
            byte_data_reg <= shift_next;
            byte_first_bit_reg <= first_reg;
            byte_valid_reg <= 1'b1;
         end
      end
   end
end

endmodule

`default_nettype wire

// File: rtl/ttr_top.v
`timescale 1ns/100ps
`default_nettype none
`include "ttr_map.vh"

// Functional notes
// - Alignment runs unless disabled; disabled capture starts at any byte
// - Expected comparison only while comparison enable is set
// - Alignment disable suppresses comparison regardless of enable
// - Inversion control inverts every incoming trace bit first
// - First received bit goes to bit 7, or bit 0 reordered
// - Expected pointer in pointer bits 11..8 selects next byte
// - Expected pointer increments per access, wrapping Fh to 0h
// - Received pointer in pointer bits 3..0 selects next byte read
// - Received pointer increments per access, wrapping Fh to 0h
// - Received data read, expected data read or write, advance pointer
// - Idle after five consecutive all-zero identifiers, held meanwhile
// - Unstable after eight identifiers matching neither stored one
// - Sticky bits set on flag rise; change sticky on update
module ttr_top (
   input wire clk,
   input wire rst_b,
   input wire trace_bit,
   input wire trace_bit_en,
   input wire trace_byte_start,
   input wire cpu_cs,
   input wire cpu_rd,
   input wire cpu_wr,
   input wire [7:0] cpu_addr,
   input wire [15:0] cpu_wdata,
   output reg [15:0] cpu_rdata_reg,
   output reg cpu_rvalid_reg
);

localparam ST_HUNT = 3'b001;
localparam ST_LOCK = 3'b010;
localparam ST_FREE = 3'b100;

function ttr_hit;
   input [7:0] addr;
   input [7:0] ofs;
   begin
      ttr_hit = (addr == ofs);
   end
endfunction

////////////////////////////////////////////////////////////////////////
// Registers and state
reg [15:0] control_reg;
reg [3:0] exp_ptr_reg;
reg [3:0] rx_ptr_reg;
reg [3:0] sticky_reg;
reg [3:0] irq_en_reg;
reg [2:0] state_reg;
reg [2:0] state_next;
reg [3:0] idx_reg;
reg [3:0] idx_next;
reg store_en;
reg [127:0] cap_reg;
reg [127:0] cand_reg;
reg [127:0] rx_id_reg;
reg id_done_reg;
reg [2:0] idle_cnt_reg;
reg [3:0] unst_cnt_reg;
reg trace_idle_flag;
reg trace_unstable_flag;
reg trace_mismatch_flag;
reg change_evt_reg;

wire [7:0] byte_data;
wire byte_first_bit;
wire byte_valid;
wire [127:0] exp_flat;
wire align_disable;
wire compare_enable;
wire compare_active;
wire rd_en;
wire wr_en;
wire exp_access;
wire rx_access;
wire [7:0] received_trace_byte;
wire [7:0] expected_trace_byte;
wire [15:0] live_word;
wire cap_zero;
wire match_cand;
wire match_rx;
wire idle_next;
wire unstable_next;
wire mismatch_next;
wire [3:0] sticky_set;
wire [3:0] sticky_clr;

assign align_disable = control_reg[`TTR_CTL_ALIGN_DIS];
assign compare_enable = control_reg[`TTR_CTL_COMPARE];
assign compare_active = compare_enable & ~align_disable;

assign rd_en = cpu_cs & cpu_rd;
assign wr_en = cpu_cs & cpu_wr;
assign exp_access = (rd_en | wr_en) & ttr_hit(cpu_addr, `TTR_OFS_EXP_BYTE);
assign rx_access = rd_en & ttr_hit(cpu_addr, `TTR_OFS_RX_BYTE);

////////////////////////////////////////////////////////////////////////
// Serial to byte conversion
ttr_deser u_deser (
   .clk(clk),
   .rst_b(rst_b),
   .trace_bit(trace_bit),
   .trace_bit_en(trace_bit_en),
   .trace_byte_start(trace_byte_start),
   .rx_invert_enable(control_reg[`TTR_CTL_INVERT]),
   .rx_bit_reorder_enable(control_reg[`TTR_CTL_REORDER]),
   .byte_data_reg(byte_data),
   .byte_first_bit_reg(byte_first_bit),
   .byte_valid_reg(byte_valid)
);

////////////////////////////////////////////////////////////////////////
// Multiframe alignment and capture
// The first bit of each byte carries the alignment marker: one in
// byte 0, zero elsewhere. A marker seen anywhere restarts the capture unless alignment is disabled.
always @* begin
   state_next = state_reg;
   idx_next = idx_reg;
   store_en = 1'b0;
   case (state_reg)
      ST_HUNT: begin
         if (align_disable) begin
            state_next = ST_FREE;
         end else if (byte_valid && byte_first_bit) begin
            state_next = ST_LOCK;
            store_en = 1'b1;
            idx_next = 4'h1;
         end
      end
      ST_LOCK: begin
         if (align_disable) begin
            state_next = ST_FREE;
         end else if (byte_valid) begin
            if (byte_first_bit) begin
               store_en = 1'b1;
               idx_next = 4'h1;
            end else if (idx_reg == 4'h0) begin
               state_next = ST_HUNT;
            end else begin
               store_en = 1'b1;
               idx_next = idx_reg + 4'h1;
            end
         end
      end
      ST_FREE: begin
         if (!align_disable) begin
            state_next = ST_HUNT;
            idx_next = 4'h0;
         end else if (byte_valid) begin
            store_en = 1'b1;
            idx_next = idx_reg + 4'h1;
         end
      end
      default: begin
         state_next = ST_HUNT;
         idx_next = 4'h0;
      end
   endcase
end

always @(posedge clk or negedge rst_b) begin
   if (!rst_b) begin
      state_reg <= ST_HUNT;
      idx_reg <= 4'h0;
      cap_reg <= `TTR_RST_IDENT;
      id_done_reg <= 1'b0;
   end else begin
      state_reg <= state_next;
      idx_reg <= idx_next;
      id_done_reg <= 1'b0;
      if (store_en) begin
         if (state_reg == ST_LOCK && byte_first_bit) begin
            cap_reg[7:0] <= byte_data;
         end else if (state_reg == ST_HUNT) begin
            cap_reg[7:0] <= byte_data;
         end else begin
            cap_reg[idx_reg*8 +: 8] <= byte_data;
            id_done_reg <= (idx_reg == 4'hf);
         end
      end
   end
end

////////////////////////////////////////////////////////////////////////
// Identifier checks
assign cap_zero = (cap_reg == 128'h0);
assign match_cand = (cap_reg == cand_reg);
assign match_rx = (cap_reg == rx_id_reg);
// five zero identifiers in a row
assign idle_next = cap_zero &&
                   (idle_cnt_reg >= (`TTR_IDLE_COUNT - 3'h1));
assign unstable_next = !(match_cand || match_rx) &&
                       (unst_cnt_reg >= (`TTR_UNSTABLE_COUNT - 4'h1));
assign mismatch_next = compare_active && (rx_id_reg != exp_flat);

always @(posedge clk or negedge rst_b) begin
   if (!rst_b) begin
      cand_reg <= `TTR_RST_IDENT;
      rx_id_reg <= `TTR_RST_IDENT;
      idle_cnt_reg <= 3'h0;
      unst_cnt_reg <= 4'h0;
      trace_idle_flag <= 1'b0;
      trace_unstable_flag <= 1'b0;
      trace_mismatch_flag <= 1'b0;
      change_evt_reg <= 1'b0;
   end else begin
      trace_mismatch_flag <= mismatch_next;
      change_evt_reg <= 1'b0;
      if (id_done_reg) begin
         cand_reg <= cap_reg;
         // Two equal identifiers in a row are taken as the new one
         if (match_cand && !match_rx) begin
            rx_id_reg <= cap_reg;
            change_evt_reg <= 1'b1;
         end
         trace_idle_flag <= idle_next;
         if (!cap_zero) begin
            idle_cnt_reg <= 3'h0;
         end else if (idle_cnt_reg != `TTR_IDLE_COUNT) begin
            idle_cnt_reg <= idle_cnt_reg + 3'h1;
         end
         trace_unstable_flag <= unstable_next;
         if (match_cand || match_rx) begin
            unst_cnt_reg <= 4'h0;
         end else if (unst_cnt_reg != `TTR_UNSTABLE_COUNT) begin
            unst_cnt_reg <= unst_cnt_reg + 4'h1;
         end
      end
   end
end

////////////////////////////////////////////////////////////////////////
// Expected identifier memory
genvar gi;
generate
   for (gi = 0; gi < `TTR_ID_BYTES; gi = gi + 1) begin : g_exp
      reg [7:0] exp_byte_reg;
      always @(posedge clk or negedge rst_b) begin
         if (!rst_b) begin
            exp_byte_reg <= 8'h00;
         end else if (wr_en && ttr_hit(cpu_addr, `TTR_OFS_EXP_BYTE) &&
                      exp_ptr_reg == gi) begin
            exp_byte_reg <= cpu_wdata[7:0];
         end
      end
      assign exp_flat[gi*8 +: 8] = exp_byte_reg;
   end
endgenerate

// expected byte chosen by its pointer
assign expected_trace_byte = exp_flat[exp_ptr_reg*8 +: 8];
// received byte chosen by its pointer
assign received_trace_byte = rx_id_reg[rx_ptr_reg*8 +: 8];

////////////////////////////////////////////////////////////////////////
// Control, pointers and status registers
// rise of a live flag or identifier update
assign sticky_set = {change_evt_reg,
                     mismatch_next & ~trace_mismatch_flag,
                     (id_done_reg & unstable_next) & ~trace_unstable_flag,
                     (id_done_reg & idle_next) & ~trace_idle_flag};
assign sticky_clr = (wr_en && ttr_hit(cpu_addr, `TTR_OFS_STICKY)) ?
                    cpu_wdata[3:0] : 4'h0;

always @(posedge clk or negedge rst_b) begin
   if (!rst_b) begin
      control_reg <= `TTR_RST_CONTROL;
      exp_ptr_reg <= 4'h0;
      rx_ptr_reg <= 4'h0;
      sticky_reg <= `TTR_RST_STATUS;
      irq_en_reg <= `TTR_RST_STATUS;
   end else begin
      // A new event wins over a clear in the same cycle
      sticky_reg <= (sticky_reg & ~sticky_clr) | sticky_set;
      if (wr_en && ttr_hit(cpu_addr, `TTR_OFS_CONTROL)) begin
         control_reg <= cpu_wdata & `TTR_CTL_MASK;
      end
      if (wr_en && ttr_hit(cpu_addr, `TTR_OFS_IRQ_EN)) begin
         irq_en_reg <= cpu_wdata[3:0];
      end
      if (wr_en && ttr_hit(cpu_addr, `TTR_OFS_POINTER)) begin
         exp_ptr_reg <= cpu_wdata[`TTR_PTR_EXP_LSB +: 4];
         rx_ptr_reg <= cpu_wdata[`TTR_PTR_RX_LSB +: 4];
      end else begin
         if (exp_access) begin
            exp_ptr_reg <= exp_ptr_reg + 4'h1;
         end
         if (rx_access) begin
            rx_ptr_reg <= rx_ptr_reg + 4'h1;
         end
      end
   end
end

////////////////////////////////////////////////////////////////////////
// Read path
assign live_word = {13'h0000, trace_mismatch_flag, trace_unstable_flag,
                    trace_idle_flag};

always @(posedge clk or negedge rst_b) begin
   if (!rst_b) begin
      cpu_rdata_reg <= 16'h0000;
      cpu_rvalid_reg <= 1'b0;
   end else begin
      cpu_rvalid_reg <= rd_en;
      if (rd_en) begin
         case (cpu_addr)
            `TTR_OFS_CONTROL: cpu_rdata_reg <= control_reg;
            `TTR_OFS_POINTER: cpu_rdata_reg <= {4'h0, exp_ptr_reg,
                                                4'h0, rx_ptr_reg};
            `TTR_OFS_LIVE: cpu_rdata_reg <= live_word;
            `TTR_OFS_STICKY: cpu_rdata_reg <= {12'h000, sticky_reg};
            `TTR_OFS_IRQ_EN: cpu_rdata_reg <= {12'h000, irq_en_reg};
            `TTR_OFS_RX_BYTE: cpu_rdata_reg <= {8'h00,
                                                received_trace_byte};
            `TTR_OFS_EXP_BYTE: cpu_rdata_reg <= {8'h00,
                                                 expected_trace_byte};
            // Unused and unmapped addresses read as zero
            default: cpu_rdata_reg <= 16'h0000;
         endcase
      end
   end
end

endmodule

`default_nettype wire

// File: bench/ttr_top_sva.sv
`timescale 1ns/100ps
`default_nettype none
module ttr_top_sva (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic trace_bit,
   input wire logic trace_bit_en,
   input wire logic trace_byte_start,
   input wire logic cpu_cs,
   input wire logic cpu_rd,
   input wire logic cpu_wr,
   input wire logic [7:0] cpu_addr,
   input wire logic [15:0] cpu_wdata,
   input wire logic [15:0] cpu_rdata_reg,
   input wire logic cpu_rvalid_reg
);
   logic [7:0] last_addr;
   logic [15:0] last_val;
   wire rd_t = cpu_cs && cpu_rd;
   wire wr_t = cpu_cs && cpu_wr;
   wire plain_reg = last_addr == 8'hf0 || last_addr == 8'hf2 ||
      last_addr == 8'hf8;

   // Read-back image of the last register write, plain or not
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         last_addr <= 8'h00;
         last_val <= 16'h0000;
      end else if (wr_t) begin
         last_addr <= cpu_addr;
         last_val <= cpu_wdata & ((cpu_addr == 8'hf2) ? 16'h0f0f : 16'h000f);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   sequence wr_gap_rd;
      wr_t ##1 !cpu_rd && !cpu_wr ##1 rd_t && cpu_addr == last_addr;
   endsequence

   read_answered_a: assert property (rd_t |=> cpu_rvalid_reg)
      else $error("read not answered");
   answer_cause_a: assert property (cpu_rvalid_reg |-> $past(rd_t))
      else $error("read data valid without a read");
   write_silent_a: assert property (wr_t && !cpu_rd |=> !cpu_rvalid_reg)
      else $error("write gave a read answer");
   rdata_hold_a: assert property (!cpu_rvalid_reg |-> $stable(cpu_rdata_reg))
      else $error("read data moved without a read");
   unmapped_zero_a: assert property (rd_t && (cpu_addr == 8'hfa ||
      cpu_addr[0] || cpu_addr < 8'hf0) |=> cpu_rdata_reg == 16'h0000)
      else $error("unmapped read not zero");
   byte_upper_zero_a: assert property (
      rd_t && cpu_addr[7:2] == 6'h3f |=> cpu_rdata_reg[15:8] == 8'h00)
      else $error("identifier data upper byte not zero");
   status_upper_zero_a: assert property (
      rd_t && (cpu_addr == 8'hf4 || cpu_addr == 8'hf6)
      |=> cpu_rdata_reg[15:4] == 12'h000)
      else $error("status upper bits not zero");
   reg_readback_a: assert property (
      wr_gap_rd ##0 plain_reg |=> cpu_rdata_reg == last_val)
      else $error("register read back differs");

   cover property (rd_t && cpu_addr == 8'hfc);
   cover property (wr_t && cpu_addr == 8'hfe);
   cover property (rd_t && cpu_addr == 8'hf4 ##1 cpu_rdata_reg[1]);
endmodule
bind ttr_top ttr_top_sva ttr_top_sva_i (
   .clk(clk),
   .rst_b(rst_b),
   .trace_bit(trace_bit),
   .trace_bit_en(trace_bit_en),
   .trace_byte_start(trace_byte_start),
   .cpu_cs(cpu_cs),
   .cpu_rd(cpu_rd),
   .cpu_wr(cpu_wr),
   .cpu_addr(cpu_addr),
   .cpu_wdata(cpu_wdata),
   .cpu_rdata_reg(cpu_rdata_reg),
   .cpu_rvalid_reg(cpu_rvalid_reg)
);
`default_nettype wire

// File: bench/ttr_trace_src.sv
`timescale 1ns/100ps
`default_nettype none
module ttr_trace_src (
   input wire logic clk,
   output var logic trace_bit,
   output var logic trace_bit_en,
   output var logic trace_byte_start
);
   logic [127:0] shift_reg = 128'h0;
   integer left = 0;

   initial begin
      trace_bit = 1'b0;
      trace_bit_en = 1'b0;
      trace_byte_start = 1'b0;
   end

   // Byte 0 first, each byte first bit first
   always @(posedge clk) begin
      if (left > 0) begin
         trace_bit <= shift_reg[127];
         trace_bit_en <= 1'b1;
         trace_byte_start <= (left % 8 == 0);
         shift_reg <= shift_reg << 1;
         left <= left - 1;
      end else begin
         // Released line toggles so a stale bit is never mistaken for data
         trace_bit <= ~trace_bit;
         trace_bit_en <= 1'b0;
         trace_byte_start <= 1'b0;
      end
   end

   task automatic send(input logic [127:0] id);
      @(negedge clk);
      shift_reg = id;
      left = 128;
      wait (left == 0);
      @(posedge clk);
   endtask
endmodule
`default_nettype wire

// File: bench/trail_trace_receiver_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "ttr_map.vh"
module trail_trace_receiver_bench;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic cpu_cs = 1'b0;
   logic cpu_rd = 1'b0;
   logic cpu_wr = 1'b0;
   logic [7:0] cpu_addr = 8'h00;
   logic [15:0] cpu_wdata = 16'h0000;
   wire logic [15:0] cpu_rdata_reg;
   wire logic cpu_rvalid_reg;
   wire logic trace_bit;
   wire logic trace_bit_en;
   wire logic trace_byte_start;
   integer fail_count = 0;
   integer samples_checked = 0;
   integer i;
   logic [127:0] a_id;

   always #50 clk = ~clk;

   ttr_top DUT (
      .clk(clk),
      .rst_b(rst_b),
      .trace_bit(trace_bit),
      .trace_bit_en(trace_bit_en),
      .trace_byte_start(trace_byte_start),
      .cpu_cs(cpu_cs),
      .cpu_rd(cpu_rd),
      .cpu_wr(cpu_wr),
      .cpu_addr(cpu_addr),
      .cpu_wdata(cpu_wdata),
      .cpu_rdata_reg(cpu_rdata_reg),
      .cpu_rvalid_reg(cpu_rvalid_reg)
   );

   ttr_trace_src src (
      .clk(clk),
      .trace_bit(trace_bit),
      .trace_bit_en(trace_bit_en),
      .trace_byte_start(trace_byte_start)
   );

   ////////////////////////////////////////////////////////////////////////
   // Marker bit leads byte 0 only; t replaces byte 1 when non-zero
   function automatic logic [127:0] mk(input logic [7:0] t);
      integer j;
      mk = 128'h0;
      for (j = 0; j < 16; j++) begin
         mk[127 - 8 * j -: 8] = 8'h10 + 8'(j);
      end
      mk[127 -: 8] = 8'hc5;
      if (t != 8'h00) mk[119 -: 8] = t;
   endfunction

   function automatic logic [7:0] rev8(input logic [7:0] b);
      integer k;
      for (k = 0; k < 8; k++) rev8[k] = b[7 - k];
   endfunction

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      cpu_cs <= 1'b1;
      cpu_wr <= 1'b1;
      cpu_addr <= a;
      cpu_wdata <= d;
      @(posedge clk);
      cpu_cs <= 1'b0;
      cpu_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      @(posedge clk);
      cpu_cs <= 1'b1;
      cpu_rd <= 1'b1;
      cpu_addr <= a;
      @(posedge clk);
      cpu_cs <= 1'b0;
      cpu_rd <= 1'b0;
      #1;
      chk({15'h0000, cpu_rvalid_reg}, 16'h0001);
      chk(cpu_rdata_reg, exp);
   endtask

   task automatic tx(input logic [127:0] id, input integer n);
      repeat (n) src.send(id);
      repeat (8) @(posedge clk);
   endtask

   task automatic rd_id(input logic [127:0] id, input logic r);
      integer j;
      logic [7:0] b;
      wr(`TTR_OFS_POINTER, 16'h0000);
      for (j = 0; j < 16; j++) begin
         b = id[127 - 8 * j -: 8];
         rd(`TTR_OFS_RX_BYTE, {8'h00, r ? rev8(b) : b});
      end
   endtask

   task conclude;
      if (fail_count == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // Whole sequence needs about 2500 cycles
   initial begin
      #(10000 * 100);
      fail_count++;
      conclude;
   end

   ////////////////////////////////////////////////////////////////////////
   initial begin
      a_id = mk(8'h00);
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      for (i = 0; i < 8; i++) rd(8'hf0 + 8'(2 * i), 16'h0000);
      rd(8'hf1, 16'h0000);
      wr(`TTR_OFS_IRQ_EN, 16'hffff);
      rd(`TTR_OFS_IRQ_EN, 16'h000f);
      wr(`TTR_OFS_LIVE, 16'hffff);
      rd(`TTR_OFS_LIVE, 16'h0000);
      wr(`TTR_OFS_POINTER, 16'hffff);
      rd(`TTR_OFS_POINTER, 16'h0f0f);
      tx(a_id, 2);
      rd_id(a_id, 1'b0);
      rd(`TTR_OFS_POINTER, 16'h0000);
      wr(`TTR_OFS_POINTER, 16'h000f);
      rd(`TTR_OFS_RX_BYTE, {8'h00, a_id[7:0]});
      rd(`TTR_OFS_POINTER, 16'h0000);
      rd(`TTR_OFS_LIVE, 16'h0000);
      wr(`TTR_OFS_POINTER, 16'h0000);
      for (i = 0; i < 16; i++) wr(`TTR_OFS_EXP_BYTE, {8'h00, a_id[127 - 8 * i -: 8]});
      rd(`TTR_OFS_POINTER, 16'h0000);
      wr(`TTR_OFS_POINTER, 16'h0f00);
      rd(`TTR_OFS_EXP_BYTE, {8'h00, a_id[7:0]});
      rd(`TTR_OFS_POINTER, 16'h0000);
      wr(`TTR_OFS_CONTROL, 16'h0004);
      rd(`TTR_OFS_LIVE, 16'h0000);
      wr(`TTR_OFS_POINTER, 16'h0500);
      wr(`TTR_OFS_EXP_BYTE, 16'h0000);
      rd(`TTR_OFS_LIVE, 16'h0004);
      rd(`TTR_OFS_STICKY, 16'h000c);
      wr(`TTR_OFS_STICKY, 16'h000f);
      rd(`TTR_OFS_STICKY, 16'h0000);
      wr(`TTR_OFS_CONTROL, 16'h000c);
      rd(`TTR_OFS_LIVE, 16'h0000);
      wr(`TTR_OFS_CONTROL, 16'h0003);
      tx(~a_id, 2);
      rd_id(a_id, 1'b1);
      // Zeros never carry a marker, so they need alignment off
      wr(`TTR_OFS_CONTROL, 16'h0008);
      tx(128'h0, 4);
      rd(`TTR_OFS_LIVE, 16'h0000);
      tx(128'h0, 1);
      rd(`TTR_OFS_LIVE, 16'h0001);
      rd(`TTR_OFS_STICKY, 16'h0009);
      wr(`TTR_OFS_STICKY, 16'h000f);
      wr(`TTR_OFS_CONTROL, 16'h0000);
      for (i = 1; i < 8; i++) tx(mk(i[7:0]), 1);
      rd(`TTR_OFS_LIVE, 16'h0000);
      tx(mk(8'h08), 1);
      rd(`TTR_OFS_LIVE, 16'h0002);
      rd(`TTR_OFS_STICKY, 16'h0002);
      conclude;
   end
endmodule
`default_nettype wire
